/* File: khp_regs.vh */
// Purpose: Constants for the keyboard host port command block
// Assumes: Included by every design file of the block
// Notes: Port addresses are the full 16-bit I/O decode
`ifndef KHP_REGS_VH
`define KHP_REGS_VH
`define KHP_DATA_PORT 16'h0060
`define KHP_CMD_PORT 16'h0064
`define KHP_ST_OBF 0
`define KHP_ST_IBF 1
`define KHP_ST_SYS 2
`define KHP_ST_CD 3
`define KHP_ST_KEYBD_ON_FLAG 4
`define KHP_ST_B5 5
`define KHP_ST_B6 6
`define KHP_ST_PARITY_FAULT 7
`define KHP_MD_EKI 0
`define KHP_MD_EMI 1
`define KHP_MD_SYS 2
`define KHP_MD_INH 3
`define KHP_MD_DKB 4
`define KHP_MD_KBD 5
`define KHP_MD_KCC 6
`define KHP_MODE_RST 8'h00
`define KHP_CMD_RDMODE 8'h20
`define KHP_CMD_WRMODE 8'h60
`define KHP_CMD_PWTEST 8'hA4
`define KHP_CMD_PWLOAD 8'hA5
`define KHP_CMD_PWEN 8'hA6
`define KHP_CMD_MSOFF 8'hA7
`define KHP_CMD_MSON 8'hA8
`define KHP_CMD_MSTEST 8'hA9
`define KHP_CMD_KBOFF 8'hAD
`define KHP_CMD_KBON 8'hAE
`define KHP_PW_YES 8'hFA
`define KHP_PW_NO 8'hF1
`define KHP_ERR_RX 8'hFF
`define KHP_ERR_TX 8'hFE
`define KHP_FRAME_BITS 11
`define KHP_PW_LEN 8
`define KHP_BIT_TMO 4'd11
`define KHP_TMO_NS 100000
`define KHP_TMO_CYC ((`KHP_TMO_NS * 250) / 1000)
`endif

/* File: khp_fifo.v */
// Purpose: Small FIFO for received serial bytes
// Assumes: Single clock, one write and one read port
// Notes: Flop storage indexed by pointers
`timescale 1ns/1ps
`include "khp_regs.vh"
module khp_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  assign o_in_ready = (cnt_reg != DEPTH);
  assign o_out_valid = (cnt_reg != 0);
  assign o_out_data = mem_reg[rp_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always @(posedge i_ref_clk)
  begin
    if (push)
      mem_reg[wp_reg] <= i_in_data;
  end
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop)
        rp_reg <= rp_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule // khp_fifo

/* File: khp_rx.v */
// Purpose: Serial frame receiver for keyboard or pointer
// Assumes: Clock and data already synchronised to i_ref_clk
// Notes: Samples data on falling edge of the serial clock
`timescale 1ns/1ps
`include "khp_regs.vh"
module khp_rx #(
  parameter TMO_CYC = `KHP_TMO_CYC
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_clk_s,
  input wire i_dat_s,
  input wire i_chk_par,
  output reg o_done,
  output reg [7:0] o_byte,
  output reg o_par_err,
  output reg o_tmo
);
  reg clk_d_reg;
  reg [3:0] cnt_reg;
  reg [9:0] sh_reg;
  reg [31:0] tmr_reg;
  wire fall;
  assign fall = clk_d_reg && !i_clk_s;
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      clk_d_reg <= 1'b1;
      cnt_reg <= 4'h0;
      sh_reg <= 10'h000;
      tmr_reg <= 32'h0;
      o_done <= 1'b0;
      o_byte <= 8'h00;
      o_par_err <= 1'b0;
      o_tmo <= 1'b0;
    end
    else
    begin
      clk_d_reg <= i_clk_s;
      o_done <= 1'b0;
      o_tmo <= 1'b0;
      if (cnt_reg != 4'h0)
        tmr_reg <= tmr_reg + 32'h1;
      else
        tmr_reg <= 32'h0;
      if (cnt_reg != 4'h0 && tmr_reg >= TMO_CYC)
      begin
        // Stuck frame abandoned so the link recovers
        o_tmo <= 1'b1;
        cnt_reg <= 4'h0;
      end
      else if (fall)
      begin
        if (cnt_reg == 4'h0)
        begin
          if (!i_dat_s)
            cnt_reg <= 4'h1;
        end
        else if (cnt_reg == `KHP_BIT_TMO - 4'd1)
        begin
          cnt_reg <= 4'h0;
          o_done <= i_dat_s;
          o_byte <= sh_reg[8:1];
          o_par_err <= i_chk_par && !(^sh_reg[9:1]);
        end
        else
        begin
          sh_reg <= {i_dat_s, sh_reg[9:1]};
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule // khp_rx

/* File: khp_host_port.v */
// What this block does
// - Serial frames: zero start, eight bits LSB first, odd parity, one stop.
// - Address bit 2 low selects data buffers, high selects status/command.
// - Select only on full sixteen-bit decode of the data or command port.
// - Output-full sets on controller load, clears on host data read.
// - Input-full sets on any host write, clears when controller takes it.
// - Command/data flag is one for command bytes, zero for data bytes.
// - Mode system bit drives the warm restart status bit.
// - Keyboard enabled status reads one unless keyboard disabled (mode bit 4) or inhibited.
// - Legacy mode bits 5 and 6 flag transmit and receive timeouts.
// - Keyboard parity error sets flag, loads all-ones, sets output-full, maybe irq; mouse parity error loads all-ones without the flag.
// - Mouse mode bit 5 shows mouse data in the output buffer.
// - Mouse mode transmit or keyboard receive timeout sets general flag, loads FE or FF.
// - Command 20 reads mode register, command 60 writes it.
// - Mode bit 0 enables keyboard interrupt on keyboard byte and command reply loads.
// - Mode bit 1 enables mouse interrupt on mouse data.
// - Mode bit 3 ignores the keyboard lock input in legacy mode.
// - Mode bit 4 holds keyboard clock, blocking keyboard reception.
// - Bit 5 skips keyboard parity checking; bit 6 is stored only, no scan code translation exists.
// - Commands 21-3F read, 61-7F write RAM at low five bits.
// - Password test answers FA or F1, sets output-full, maybe irq.
// - Password load takes bytes until zero or eight stored.
// - Security on discards device characters until password matches.
// - A7 sets mode bit 5 and, in PS/2 mode only, holds mouse clock; A8 clears it.
// - Mouse test reports 00 ok, 01 for clock stuck low, 03 for data stuck low.
// Purpose: Host data/command port with minimal command interpreter
// Assumes: Host I/O strobes are one-cycle pulses on i_ref_clk
// Notes: Received bytes queue in a FIFO ahead of the output buffer
`timescale 1ns/1ps
`include "khp_regs.vh"
module khp_host_port #(
  parameter TMO_CYC = `KHP_TMO_CYC,
  parameter FIFO_DEPTH = 16
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [15:0] i_io_addr,
  input wire i_io_rd,
  input wire i_io_wr,
  input wire [7:0] i_io_wdata,
  output reg [7:0] o_io_rdata,
  input wire i_ps2_mode,
  input wire i_kb_lock,
  input wire i_kb_clk,
  input wire i_kb_dat,
  input wire i_ms_clk,
  input wire i_ms_dat,
  input wire i_tx_tmo,
  output reg o_kb_clock_line_oe_n,
  output reg o_pointer_clock_line_oe_n,
  output reg o_kb_irq_out,
  output reg o_pointer_irq_out
);
  reg [1:0] kc_sync_reg;
  reg [1:0] kd_sync_reg;
  reg [1:0] mc_sync_reg;
  reg [1:0] md_sync_reg;
  reg [1:0] lk_sync_reg;
  reg [1:0] ps_sync_reg;
  reg [1:0] tt_sync_reg;
  reg [7:0] out_buf_reg;
  reg [7:0] in_buf_reg;
  reg [7:0] mode_reg;
  reg out_buf_full_reg;
  reg in_buf_full_reg;
  reg cmd_flag_reg;
  reg outbuf_from_pointer_reg;
  reg tx_timeout_reg;
  reg rx_timeout_reg;
  reg general_timeout_reg;
  reg parity_fault_reg;
  reg [7:0] ram_reg [0:31];
  reg [7:0] pw_reg [0:7];
  reg [3:0] pw_cnt_reg;
  reg [3:0] pw_chk_reg;
  reg pw_set_reg;
  reg secure_reg;
  reg ms_off_reg;
  reg [2:0] state_reg;
  reg [4:0] ram_addr_reg;
  reg tt_d_reg;
  integer k;
  localparam ST_IDLE = 3'd0;
  localparam ST_WRMODE = 3'd1;
  localparam ST_WRRAM = 3'd2;
  localparam ST_PWLOAD = 3'd3;
  wire sel_data;
  wire sel_cmd;
  wire host_rd_data;
  wire host_wr;
  wire kb_done;
  wire [7:0] kb_byte;
  wire kb_parity_fault;
  wire kb_tmo;
  wire ms_done;
  wire [7:0] ms_byte;
  wire ms_parity_fault;
  wire ms_tmo;
  wire [7:0] status;
  wire kb_on;
  wire ps2;
  wire f_in_ready;
  wire f_out_valid;
  wire [8:0] f_out_data;
  wire [8:0] f_in_data;
  wire f_in_valid;
  wire f_take;
  wire tx_tmo_evt;
  assign sel_data = (i_io_addr == `KHP_DATA_PORT);
  assign sel_cmd = (i_io_addr == `KHP_CMD_PORT);
  assign host_rd_data = i_io_rd && sel_data && !i_io_addr[2];
  assign host_wr = i_io_wr && (sel_data || sel_cmd);
  assign ps2 = ps_sync_reg[1];
  assign tx_tmo_evt = tt_sync_reg[1] && !tt_d_reg;
  assign kb_on = !mode_reg[`KHP_MD_DKB] &&
    (mode_reg[`KHP_MD_INH] || ps2 || lk_sync_reg[1]);
  assign status = {parity_fault_reg,
    ps2 ? general_timeout_reg : rx_timeout_reg,
    ps2 ? outbuf_from_pointer_reg : tx_timeout_reg,
    kb_on,
    cmd_flag_reg, mode_reg[`KHP_MD_SYS],
    in_buf_full_reg, out_buf_full_reg};
  // Keyboard frames with a parity fault pass as FF
  function [8:0] dev_word;
    input is_ms;
    input [7:0] b;
    input parity_fault;
    begin
      dev_word = {is_ms, parity_fault ? `KHP_ERR_RX : b};
    end
  endfunction
  // Security and disable drop device characters before queueing
  assign f_in_valid = (kb_done && kb_on && !secure_reg) ||
    (ms_done && ps2 && !ms_off_reg && !secure_reg);
  assign f_in_data = kb_done ? dev_word(1'b0, kb_byte, kb_parity_fault) :
    dev_word(1'b1, ms_byte, ms_parity_fault);
  assign f_take = f_out_valid && !out_buf_full_reg && !in_buf_full_reg;
  khp_rx #(.TMO_CYC(TMO_CYC)) u_kb_rx (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_s(kc_sync_reg[1]),
    .i_dat_s(kd_sync_reg[1]),
    .i_chk_par(!mode_reg[`KHP_MD_KBD]),
    .o_done(kb_done),
    .o_byte(kb_byte),
    .o_par_err(kb_parity_fault),
    .o_tmo(kb_tmo)
  );
  khp_rx #(.TMO_CYC(TMO_CYC)) u_ms_rx (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_s(mc_sync_reg[1]),
    .i_dat_s(md_sync_reg[1]),
    .i_chk_par(1'b1),
    .o_done(ms_done),
    .o_byte(ms_byte),
    .o_par_err(ms_parity_fault),
    .o_tmo(ms_tmo)
  );
  khp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(f_in_valid),
    .o_in_ready(f_in_ready),
    .i_in_data(f_in_data),
    .o_out_valid(f_out_valid),
    .i_out_ready(f_take),
    .o_out_data(f_out_data)
  );
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      kc_sync_reg <= 2'b11;
      kd_sync_reg <= 2'b11;
      mc_sync_reg <= 2'b11;
      md_sync_reg <= 2'b11;
      lk_sync_reg <= 2'b00;
      ps_sync_reg <= 2'b00;
      tt_sync_reg <= 2'b00;
      tt_d_reg <= 1'b0;
    end
    else
    begin
      kc_sync_reg <= {kc_sync_reg[0], i_kb_clk};
      kd_sync_reg <= {kd_sync_reg[0], i_kb_dat};
      mc_sync_reg <= {mc_sync_reg[0], i_ms_clk};
      md_sync_reg <= {md_sync_reg[0], i_ms_dat};
      lk_sync_reg <= {lk_sync_reg[0], i_kb_lock};
      ps_sync_reg <= {ps_sync_reg[0], i_ps2_mode};
      tt_sync_reg <= {tt_sync_reg[0], i_tx_tmo};
      tt_d_reg <= tt_sync_reg[1];
    end
  end
  always @(posedge i_ref_clk)
  begin
    // Only data bytes count; a command or a fresh write must not land
    if (state_reg == ST_WRRAM && in_buf_full_reg && !cmd_flag_reg &&
        !host_wr)
      ram_reg[ram_addr_reg] <= in_buf_reg;
    if (state_reg == ST_PWLOAD && in_buf_full_reg && !pw_cnt_reg[3] &&
        !cmd_flag_reg && !host_wr)
      pw_reg[pw_cnt_reg[2:0]] <= in_buf_reg;
  end
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_buf_reg <= 8'h00;
      in_buf_reg <= 8'h00;
      mode_reg <= `KHP_MODE_RST;
      out_buf_full_reg <= 1'b0;
      in_buf_full_reg <= 1'b0;
      cmd_flag_reg <= 1'b0;
      outbuf_from_pointer_reg <= 1'b0;
      tx_timeout_reg <= 1'b0;
      rx_timeout_reg <= 1'b0;
      general_timeout_reg <= 1'b0;
      parity_fault_reg <= 1'b0;
      pw_cnt_reg <= 4'h0;
      pw_chk_reg <= 4'h0;
      pw_set_reg <= 1'b0;
      secure_reg <= 1'b0;
      ms_off_reg <= 1'b0;
      state_reg <= ST_IDLE;
      ram_addr_reg <= 5'h00;
      o_io_rdata <= 8'h00;
      o_kb_irq_out <= 1'b0;
      o_pointer_irq_out <= 1'b0;
      o_kb_clock_line_oe_n <= 1'b1;
      o_pointer_clock_line_oe_n <= 1'b1;
    end
    else
    begin
      o_kb_irq_out <= 1'b0;
      o_pointer_irq_out <= 1'b0;
      // Pin held while disabled; low enable means driven
      o_kb_clock_line_oe_n <= !mode_reg[`KHP_MD_DKB];
      o_pointer_clock_line_oe_n <= !(ps2 && ms_off_reg);
      if (i_io_rd && (sel_data || sel_cmd))
        o_io_rdata <= i_io_addr[2] ? status : out_buf_reg;
      if (host_rd_data)
        out_buf_full_reg <= 1'b0;
      if (kb_tmo || tx_tmo_evt)
      begin
        if (ps2)
        begin
          general_timeout_reg <= 1'b1;
          out_buf_reg <= kb_tmo ? `KHP_ERR_RX : `KHP_ERR_TX;
          out_buf_full_reg <= 1'b1;
        end
        else if (kb_tmo)
          rx_timeout_reg <= 1'b1;
        else
          tx_timeout_reg <= 1'b1;
      end
      // Password match scans keyboard bytes while secured
      if (kb_done && secure_reg)
      begin
        if (pw_reg[pw_chk_reg[2:0]] != kb_byte)
          pw_chk_reg <= 4'h0;
        else if (pw_reg[pw_chk_reg[2:0] + 3'd1] == 8'h00)
        begin
          secure_reg <= 1'b0;
          pw_chk_reg <= 4'h0;
        end
        else
          pw_chk_reg <= pw_chk_reg + 4'h1;
      end
      // Host write beats controller consume in the same cycle
      if (host_wr)
      begin
        in_buf_reg <= i_io_wdata;
        in_buf_full_reg <= 1'b1;
        cmd_flag_reg <= i_io_addr[2];
      end
      else if (in_buf_full_reg)
      begin
        in_buf_full_reg <= 1'b0;
        if (cmd_flag_reg)
        begin
          state_reg <= ST_IDLE;
          case (in_buf_reg)
            `KHP_CMD_RDMODE:
            begin
              out_buf_reg <= mode_reg;
              out_buf_full_reg <= 1'b1;
              outbuf_from_pointer_reg <= 1'b0;
              o_kb_irq_out <= mode_reg[`KHP_MD_EKI];
            end
            `KHP_CMD_WRMODE: state_reg <= ST_WRMODE;
            `KHP_CMD_PWTEST:
            begin
              out_buf_reg <= pw_set_reg ? `KHP_PW_YES : `KHP_PW_NO;
              out_buf_full_reg <= 1'b1;
              outbuf_from_pointer_reg <= 1'b0;
              o_kb_irq_out <= mode_reg[`KHP_MD_EKI];
            end
            `KHP_CMD_PWLOAD:
            begin
              state_reg <= ST_PWLOAD;
              pw_cnt_reg <= 4'h0;
              pw_set_reg <= 1'b0;
            end
            `KHP_CMD_PWEN: secure_reg <= pw_set_reg;
            `KHP_CMD_MSOFF:
            begin
              mode_reg[`KHP_MD_KBD] <= 1'b1;
              ms_off_reg <= 1'b1;
            end
            `KHP_CMD_MSON:
            begin
              mode_reg[`KHP_MD_KBD] <= 1'b0;
              ms_off_reg <= 1'b0;
            end
            `KHP_CMD_MSTEST:
            begin
              // Idle lines must float high; low means stuck
              out_buf_reg <= !mc_sync_reg[1] ? 8'h01 :
                (!md_sync_reg[1] ? 8'h03 : 8'h00);
              out_buf_full_reg <= 1'b1;
              outbuf_from_pointer_reg <= 1'b0;
              o_kb_irq_out <= mode_reg[`KHP_MD_EKI];
            end
            `KHP_CMD_KBOFF: mode_reg[`KHP_MD_DKB] <= 1'b1;
            `KHP_CMD_KBON: mode_reg[`KHP_MD_DKB] <= 1'b0;
            default:
            begin
              if (in_buf_reg[7:5] == 3'b001)
              begin
                out_buf_reg <= ram_reg[in_buf_reg[4:0]];
                out_buf_full_reg <= 1'b1;
                outbuf_from_pointer_reg <= 1'b0;
                o_kb_irq_out <= mode_reg[`KHP_MD_EKI];
              end
              else if (in_buf_reg[7:5] == 3'b011)
              begin
                ram_addr_reg <= in_buf_reg[4:0];
                state_reg <= ST_WRRAM;
              end
            end
          endcase
        end
        else
        begin
          case (state_reg)
            ST_WRMODE: mode_reg <= in_buf_reg;
            ST_PWLOAD:
            begin
              pw_cnt_reg <= pw_cnt_reg + 4'h1;
              if (in_buf_reg == 8'h00 || pw_cnt_reg == 4'd7)
                pw_set_reg <= 1'b1;
            end
            default: ;
          endcase
          if (state_reg != ST_PWLOAD || in_buf_reg == 8'h00 ||
              pw_cnt_reg == 4'd7)
            state_reg <= ST_IDLE;
        end
      end
      else if (f_take)
      begin
        out_buf_reg <= f_out_data[7:0];
        out_buf_full_reg <= 1'b1;
        outbuf_from_pointer_reg <= f_out_data[8];
        parity_fault_reg <= !f_out_data[8] &&
          f_out_data[7:0] == `KHP_ERR_RX;
        o_kb_irq_out <= !f_out_data[8] && mode_reg[`KHP_MD_EKI];
        o_pointer_irq_out <= f_out_data[8] && ps2 &&
          mode_reg[`KHP_MD_EMI];
      end
    end
  end
endmodule // khp_host_port

/* File: khp_host_port_monitor.sv */
// Purpose: Concurrent checks on the host port pins
// Assumes: Bound to khp_host_port, single clock domain
// Notes: Clock-line holds may only move shortly after a host cause
`timescale 1ns/1ps
module khp_host_port_monitor (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [15:0] i_io_addr,
  input wire i_io_rd,
  input wire i_io_wr,
  input wire [7:0] o_io_rdata,
  input wire i_ps2_mode,
  input wire o_kb_clock_line_oe_n,
  input wire o_pointer_clock_line_oe_n,
  input wire o_kb_irq_out,
  input wire o_pointer_irq_out
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  reg [3:0] since_reg;
  reg mode_q_reg;
  wire sel = (i_io_addr == 16'h0060) || (i_io_addr == 16'h0064);
  // Mode pin passes synchronisers, so its change counts as a cause
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      since_reg <= 4'hF;
      mode_q_reg <= 1'b0;
    end
    else
    begin
      mode_q_reg <= i_ps2_mode;
      if ((i_io_wr && sel) || (i_ps2_mode != mode_q_reg))
        since_reg <= 4'h0;
      else if (since_reg != 4'hF)
        since_reg <= since_reg + 4'h1;
    end
  end
  sequence s_quiet;
    !o_kb_irq_out && !o_pointer_irq_out;
  endsequence
  sequence s_clk_free;
    o_kb_clock_line_oe_n && o_pointer_clock_line_oe_n;
  endsequence
  a_kb_irq_pulse:
    assert property (o_kb_irq_out |=> !o_kb_irq_out)
    else $error("keyboard irq longer than one cycle");
  a_ptr_irq_pulse:
    assert property (o_pointer_irq_out |=> !o_pointer_irq_out)
    else $error("pointer irq longer than one cycle");
  a_irq_one_source:
    assert property (!(o_kb_irq_out && o_pointer_irq_out))
    else $error("both irqs for one load");
  a_rdata_holds:
    assert property (!i_io_rd |=> $stable(o_io_rdata))
    else $error("read data moved without a read");
  a_bad_addr_ignored:
    assert property (i_io_rd && !sel |=> $stable(o_io_rdata))
    else $error("read at foreign address answered");
  a_reset_irq_quiet:
    assert property ($rose(i_rst_n) |-> s_quiet [*2])
    else $error("irq right after reset");
  a_reset_clk_free:
    assert property ($rose(i_rst_n) |-> s_clk_free)
    else $error("clock line held after reset");
  a_kb_clk_cause:
    assert property ($changed(o_kb_clock_line_oe_n) |-> since_reg < 4'h8)
    else $error("keyboard clock hold moved without cause");
  a_ptr_clk_cause:
    assert property ($changed(o_pointer_clock_line_oe_n) |-> since_reg < 4'h8)
    else $error("pointer clock hold moved without cause");
endmodule // khp_host_port_monitor
bind khp_host_port khp_host_port_monitor u_mon (.i_ref_clk, .i_rst_n,
  .i_io_addr, .i_io_rd, .i_io_wr, .o_io_rdata, .i_ps2_mode,
  .o_kb_clock_line_oe_n, .o_pointer_clock_line_oe_n, .o_kb_irq_out,
  .o_pointer_irq_out);

/* File: khp_serial_dev.sv */
// Purpose: Keyboard or pointer device sending serial frames
// Assumes: Open-drain lines with pull-ups, so idle reads high
// Notes: Clock stands high between frames; nbits below 11 truncates
`timescale 1ns/1ps
module khp_serial_dev (
  output logic o_clk,
  output logic o_dat
);
  initial
  begin
    o_clk = 1'b1;
    o_dat = 1'b1;
  end
  task automatic send(input logic [7:0] b, input logic bad,
    input int nbits, input int hp);
    logic [10:0] f;
    f = {1'b1, (~^b) ^ bad, b, 1'b0};
    for (int i = 0; i < nbits; i++)
    begin
      o_dat = f[i];
      #(hp) o_clk = 1'b0;
      #(hp) o_clk = 1'b1;
    end
    o_dat = 1'b1;
  endtask
endmodule // khp_serial_dev

/* File: tb_khp_host_port.sv */
// Purpose: Self-checking bench for the host port command block
// Assumes: Host strobes change on rising edges by non-blocking writes
// Notes: Short timeout parameter keeps truncated frames quick
`timescale 1ns/1ps
module tb_khp_host_port;
  localparam logic [15:0] da = 16'h0060;
  localparam logic [15:0] ca = 16'h0064;
  logic i_ref_clk, i_rst_n, i_io_rd, i_io_wr, i_ps2_mode, i_kb_lock;
  logic i_tx_tmo;
  logic [15:0] i_io_addr;
  logic [7:0] i_io_wdata, v;
  wire [7:0] o_io_rdata;
  wire o_kb_clock_line_oe_n, o_pointer_clock_line_oe_n;
  wire o_kb_irq_out, o_pointer_irq_out, kd_clk, kd_dat, md_clk, md_dat;
  int num_errors = 0;
  int comparisons = 0;
  int kb_irq_out = 0;
  int pointer_irq_out = 0;
  khp_serial_dev kb_dev (.o_clk(kd_clk), .o_dat(kd_dat));
  khp_serial_dev ms_dev (.o_clk(md_clk), .o_dat(md_dat));
  // Held clock line wins over the device's own clock
  khp_host_port #(.TMO_CYC(200), .FIFO_DEPTH(16)) uut (.i_ref_clk,
    .i_rst_n, .i_io_addr, .i_io_rd, .i_io_wr, .i_io_wdata, .o_io_rdata,
    .i_ps2_mode, .i_kb_lock, .i_kb_clk(kd_clk & o_kb_clock_line_oe_n),
    .i_kb_dat(kd_dat), .i_ms_clk(md_clk & o_pointer_clock_line_oe_n),
    .i_ms_dat(md_dat), .i_tx_tmo, .o_kb_clock_line_oe_n,
    .o_pointer_clock_line_oe_n, .o_kb_irq_out, .o_pointer_irq_out);
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  // Counted on the far edge to stay clear of the launch edge
  always @(negedge i_ref_clk)
  begin
    if (o_kb_irq_out === 1'b1)
      kb_irq_out++;
    if (o_pointer_irq_out === 1'b1)
      pointer_irq_out++;
  end
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_io_addr <= a;
    i_io_wdata <= d;
    i_io_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_io_wr <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    i_io_addr <= a;
    i_io_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_io_rd <= 1'b0;
    #1 d = o_io_rdata;
    @(posedge i_ref_clk);
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e,
    input string n);
    rd(a, v);
    chk(n, e, v);
  endtask
  task automatic wait_st(input int b);
    for (int n = 0; n < 300; n++)
    begin
      rd(ca, v);
      if (v[b] === 1'b1)
        return;
    end
    chk("status wait", 8'h01 << b, v);
    test_done();
  endtask
  task automatic setm(input logic [7:0] m);
    wr(ca, 8'h60);
    wr(da, m);
  endtask
  task automatic cmdr(input logic [7:0] c, input logic [7:0] e,
    input string n);
    wr(ca, c);
    wait_st(0);
    rc(da, e, n);
  endtask
  task automatic oe_chk(input logic k, input logic e, input string n);
    logic s;
    for (int c = 0; c < 20; c++)
    begin
      s = k ? o_kb_clock_line_oe_n : o_pointer_clock_line_oe_n;
      if (s !== e)
        @(posedge i_ref_clk);
    end
    chk(n, {7'h0, e}, {7'h0, s});
  endtask
  task automatic t_mode();
    int k;
    rc(ca, 8'h10, "reset status");
    setm(8'h45);
    k = kb_irq_out;
    wr(ca, 8'h20);
    wait_st(0);
    rc(ca, 8'h1D, "cmd status");
    rc(da, 8'h45, "mode");
    rc(ca, 8'h1C, "after read");
    chk("kb irq", 8'h01, 8'(kb_irq_out - k));
  endtask
  task automatic t_badaddr();
    logic [15:0] a [3] = '{16'h0160, 16'h0061, 16'h0464};
    foreach (a[i])
      wr(a[i], 8'h20);
    rc(ca, 8'h1C, "foreign write");
    rd(16'h0160, v);
    chk("foreign read", 8'h1C, v);
  endtask
  task automatic t_lock();
    i_kb_lock <= 1'b0;
    setm(8'h45);
    rc(ca, 8'h04, "locked");
    setm(8'h4D);
    rc(ca, 8'h14, "bypass");
    i_kb_lock <= 1'b1;
    wr(ca, 8'hAD);
    oe_chk(1'b1, 1'b0, "kb clk held");
    wr(ca, 8'hAE);
    oe_chk(1'b1, 1'b1, "kb clk free");
  endtask
  task automatic t_rx();
    int k;
    setm(8'h01);
    k = kb_irq_out;
    kb_dev.send(8'h5A, 1'b0, 11, 24);
    wait_st(0);
    rc(da, 8'h5A, "rx byte");
    kb_dev.send(8'hA5, 1'b1, 11, 28);
    wait_st(0);
    rc(ca, 8'h91, "parity status");
    rc(da, 8'hFF, "parity byte");
    chk("kb irqs", 8'h02, 8'(kb_irq_out - k));
    setm(8'h21);
    kb_dev.send(8'h3C, 1'b1, 11, 24);
    wait_st(0);
    rc(da, 8'h3C, "old kb byte");
  endtask
  task automatic t_fifo();
    // One byte in the output buffer plus sixteen queued
    for (int i = 0; i < 17; i++)
      kb_dev.send(8'h40 + 8'(i), 1'b0, 11, 20);
    for (int i = 0; i < 17; i++)
    begin
      wait_st(0);
      rc(da, 8'h40 + 8'(i), "queued byte");
    end
  endtask
  task automatic t_ram();
    for (int i = 1; i < 32; i += 30)
      setm(8'h60 + 8'(i));
    for (int i = 1; i < 32; i += 30)
    begin
      wr(ca, 8'h60 + 8'(i));
      wr(da, 8'h90 + 8'(i));
    end
    for (int i = 1; i < 32; i += 30)
      cmdr(8'h20 + 8'(i), 8'h90 + 8'(i), "ram");
  endtask
  task automatic t_ps2();
    int k;
    int m;
    i_ps2_mode <= 1'b1;
    setm(8'h03);
    k = kb_irq_out;
    m = pointer_irq_out;
    ms_dev.send(8'h08, 1'b0, 11, 24);
    wait_st(0);
    rc(ca, 8'h31, "mouse status");
    rc(da, 8'h08, "mouse byte");
    chk("ms irq", 8'h01, 8'(pointer_irq_out - m));
    chk("no kb irq", 8'h00, 8'(kb_irq_out - k));
    wr(ca, 8'hA7);
    oe_chk(1'b0, 1'b0, "ms clk held");
    cmdr(8'h20, 8'h23, "mode off");
    wr(ca, 8'hA8);
    oe_chk(1'b0, 1'b1, "ms clk free");
    cmdr(8'h20, 8'h03, "mode on");
    cmdr(8'hA9, 8'h00, "ms test");
    cmdr(8'hA4, 8'hF1, "no password");
    wr(ca, 8'hA5);
    wr(da, 8'h31);
    wr(da, 8'h32);
    wr(da, 8'h00);
    cmdr(8'hA4, 8'hFA, "password");
    wr(ca, 8'hA6);
    kb_dev.send(8'h31, 1'b0, 11, 24);
    kb_dev.send(8'h32, 1'b0, 11, 24);
    repeat (8) @(posedge i_ref_clk);
    rc(ca, 8'h18, "secured drop");
    kb_dev.send(8'h5A, 1'b0, 11, 24);
    wait_st(0);
    rc(da, 8'h5A, "unlocked byte");
    kb_dev.send(8'h55, 1'b0, 4, 24);
    wait_st(0);
    chk("general tmo", 8'h40, v & 8'h40);
    rc(da, 8'hFF, "tmo byte");
  endtask
  task automatic t_txtmo();
    i_ps2_mode <= 1'b0;
    i_tx_tmo <= 1'b1;
    wait_st(5);
    chk("tx tmo", 8'h20, v & 8'h20);
    i_tx_tmo <= 1'b0;
  endtask
  initial
  begin
    i_rst_n = 1'b0;
    i_io_rd = 1'b0;
    i_io_wr = 1'b0;
    i_io_addr = 16'h0000;
    i_io_wdata = 8'h00;
    i_ps2_mode = 1'b0;
    i_kb_lock = 1'b1;
    i_tx_tmo = 1'b0;
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    chk("clk holds", 8'h03,
      {6'h0, o_kb_clock_line_oe_n, o_pointer_clock_line_oe_n});
    t_mode();
    t_badaddr();
    t_lock();
    t_rx();
    t_fifo();
    t_ram();
    t_ps2();
    t_txtmo();
    test_done();
  end
endmodule // tb_khp_host_port
